// [rtl/atatf_regs.vh]
// Register offsets, field positions and codes of the task-file bank.
`ifndef ATATF_REGS_VH
`define ATATF_REGS_VH
`define ATATF_OFS_DATA      3'h0
`define ATATF_OFS_ERRFEAT   3'h1
`define ATATF_OFS_SECCNT    3'h2
`define ATATF_OFS_SECNUM    3'h3
`define ATATF_OFS_CYLLO     3'h4
`define ATATF_OFS_CYLHI     3'h5
`define ATATF_OFS_DRVHEAD   3'h6
`define ATATF_OFS_STATCMD   3'h7
`define ATATF_OFS_ALTCTL    3'h6
`define ATATF_OFS_DRVADDR   3'h7
`define ATATF_ERR_BBK_BIT   7
`define ATATF_ERR_UNC_BIT   6
`define ATATF_ERR_SECTOR_NOT_FOUND_FLAG_BIT  4
`define ATATF_ERR_ABORTED_FLAG_BIT  2
`define ATATF_ERR_GEN_BIT   0
`define ATATF_DH_MODE_BIT   6
`define ATATF_DH_DRV_BIT    4
`define ATATF_ST_ERR_BIT    0
`define ATATF_BYTE_ZERO     8'h00
`define ATATF_WORD_ZERO     16'h0000
`define ATATF_DEVCTL_RESET  8'h08
`define ATATF_STATUS_RESET  8'h50
`endif

// [rtl/atatf_task_file.v]
// Task-file register bank of a parallel ATA flash drive.
// Operation
// - Control block 6h: alternate status, device control.
// - Control block 7h: drive address read, write ignored.
// - Command block 1h: error read, feature write.
// - 7h status/command; 2h-6h read back writes.
// - 16-bit data port, word or byte mode.
// - Error register read-only, fixed flag layout.
// - Bad-block and uncorrectable flags from core.
// - Sector-not-found, aborted, general error flags.
// - Feature register write-only, before command.
// - Sector count written, updated with remainder.
// - Sector number start, updated on completion.
// - Cylinder low start, updated on completion.
// - Cylinder high start, updated on completion.
// - Mode bit 6: CHS or block addressing.
// - Drive select bit 4 picks drive.
// - Low nibble: head or block address top.
// - Decode only with exactly one chip select.
// - Read and write strobes are low pulses.
// - Assert 16-bit indication for data port in word mode only.
// - Cable select grounded means drive zero.
`timescale 1ns/1ps
`include "atatf_regs.vh"
module atatf_task_file #(
    parameter DATA_W = 16
) (
    input  wire              mclk_in,
    input  wire              reset_in,
    input  wire              clk_en_in,
    input  wire              cs0_n_in,
    input  wire              cs1_n_in,
    input  wire [2:0]        da_in,
    input  wire              dior_n_in,
    input  wire              diow_n_in,
    input  wire [DATA_W-1:0] dd_in,
    input  wire              csel_in,
    input  wire              byte_mode_in,
    input  wire [DATA_W-1:0] buf_rd_data_in,
    input  wire [7:0]        core_status_in,
    input  wire              core_done_in,
    input  wire [7:0]        core_seccnt_in,
    input  wire [27:0]       core_addr_in,
    input  wire              core_writing_in,
    input  wire              err_bad_block_in,
    input  wire              err_uncorr_in,
    input  wire              err_not_found_in,
    input  wire              err_aborted_in,
    input  wire              err_general_in,
    output reg  [DATA_W-1:0] dd_out,
    output reg               dd_oe_out,
    output reg               iocs16_n_out,
    output reg               iocs16_oe_out,
    output reg               buf_rd_out,
    output reg               buf_wr_out,
    output reg  [DATA_W-1:0] buf_wr_data_out,
    output reg               cmd_start_out,
    output reg  [7:0]        command_code_out,
    output reg  [7:0]        feature_param_out,
    output reg  [7:0]        device_control_out,
    output reg               addressing_mode_bit_out,
    output reg  [3:0]        head_select_field_out,
    output reg  [27:0]       start_addr_out,
    output reg  [7:0]        sector_count_out,
    output reg               drive_role_out
);

// ****************************************
// Decode and strobe edges.
// ****************************************
reg        dior_q;
reg        diow_q;
reg        odd_phase;
reg [7:0]  odd_byte;
reg [7:0]  error_flags;
reg [7:0]  sector_number;
reg [7:0]  cylinder_low_byte;
reg [7:0]  cylinder_high_byte;
reg [7:0]  drive_head_select;
reg [7:0]  status_primary;
reg [7:0]  next_rd;
reg [DATA_W-1:0] next_word;

wire cmd_blk = ~cs0_n_in & cs1_n_in;
wire ctl_blk = cs0_n_in & ~cs1_n_in;
wire rd_fall = ~dior_n_in & dior_q;
wire wr_fall = ~diow_n_in & diow_q;
wire drive_select_bit = drive_head_select[`ATATF_DH_DRV_BIT];
wire selected = (drive_select_bit == drive_role_out);
wire data_acc = cmd_blk & (da_in == `ATATF_OFS_DATA);
wire bad_blk = error_flags[`ATATF_ERR_BBK_BIT];
wire data_ok = data_acc & ~bad_blk;
wire cmd_wr = wr_fall & selected &
              hit(cmd_blk, da_in, `ATATF_OFS_STATCMD);

function hit;
    input       blk;
    input [2:0] a;
    input [2:0] ofs;
    begin
        hit = blk & (a == ofs);
    end
endfunction

// ****************************************
// Read multiplexer.
// ****************************************
always @* begin
    next_rd = `ATATF_BYTE_ZERO;
    if (hit(cmd_blk, da_in, `ATATF_OFS_ERRFEAT)) begin
        next_rd = error_flags;
    end else if (hit(cmd_blk, da_in, `ATATF_OFS_SECCNT)) begin
        next_rd = sector_count_out;
    end else if (hit(cmd_blk, da_in, `ATATF_OFS_SECNUM)) begin
        next_rd = sector_number;
    end else if (hit(cmd_blk, da_in, `ATATF_OFS_CYLLO)) begin
        next_rd = cylinder_low_byte;
    end else if (hit(cmd_blk, da_in, `ATATF_OFS_CYLHI)) begin
        next_rd = cylinder_high_byte;
    end else if (hit(cmd_blk, da_in, `ATATF_OFS_DRVHEAD)) begin
        next_rd = drive_head_select;
    end else if (hit(cmd_blk, da_in, `ATATF_OFS_STATCMD)) begin
        next_rd = status_primary;
    end else if (hit(ctl_blk, da_in, `ATATF_OFS_ALTCTL)) begin
        next_rd = status_primary;
    end else if (hit(ctl_blk, da_in, `ATATF_OFS_DRVADDR)) begin
        next_rd = {1'b1, ~core_writing_in,
                   ~drive_head_select[3:0],
                   ~(selected & drive_role_out),
                   ~(selected & ~drive_role_out)};
    end
end

always @* begin
    next_word = buf_rd_data_in;
    if (byte_mode_in) begin
        next_word = {`ATATF_BYTE_ZERO,
                     odd_phase ? odd_byte : buf_rd_data_in[7:0]};
    end
end

// ****************************************
// Register state.
// ****************************************
always @(posedge mclk_in) begin
    if (reset_in) begin
        dior_q <= 1'b1;
        diow_q <= 1'b1;
        odd_phase <= 1'b0;
        odd_byte <= `ATATF_BYTE_ZERO;
        sector_number <= `ATATF_BYTE_ZERO;
        cylinder_low_byte <= `ATATF_BYTE_ZERO;
        cylinder_high_byte <= `ATATF_BYTE_ZERO;
        drive_head_select <= `ATATF_BYTE_ZERO;
        dd_out <= `ATATF_WORD_ZERO;
        dd_oe_out <= 1'b0;
        iocs16_n_out <= 1'b1;
        iocs16_oe_out <= 1'b0;
        buf_rd_out <= 1'b0;
        buf_wr_out <= 1'b0;
        buf_wr_data_out <= `ATATF_WORD_ZERO;
        cmd_start_out <= 1'b0;
        command_code_out <= `ATATF_BYTE_ZERO;
        feature_param_out <= `ATATF_BYTE_ZERO;
        device_control_out <= `ATATF_DEVCTL_RESET;
        addressing_mode_bit_out <= 1'b0;
        head_select_field_out <= 4'h0;
        start_addr_out <= 28'h0000000;
        sector_count_out <= `ATATF_BYTE_ZERO;
        drive_role_out <= 1'b0;
    end else if (clk_en_in) begin
        dior_q <= dior_n_in;
        diow_q <= diow_n_in;
        buf_rd_out <= 1'b0;
        buf_wr_out <= 1'b0;
        cmd_start_out <= 1'b0;
        drive_role_out <= csel_in;
        iocs16_n_out <= ~(data_acc & selected & ~byte_mode_in);
        iocs16_oe_out <= data_acc & selected & ~byte_mode_in;
        dd_oe_out <= ~dior_n_in & (cmd_blk | ctl_blk) & selected;
        // ****************************************
        // Host reads.
        // ****************************************
        if (rd_fall & selected) begin
            if (data_ok) begin
                dd_out <= next_word;
                if (~byte_mode_in | odd_phase) begin
                    buf_rd_out <= 1'b1;
                end
                odd_byte <= buf_rd_data_in[15:8];
                odd_phase <= byte_mode_in & ~odd_phase;
            end else begin
                dd_out <= {`ATATF_BYTE_ZERO, next_rd};
            end
        end
        // ****************************************
        // Host writes.
        // ****************************************
        if (wr_fall & data_ok & selected) begin
            if (~byte_mode_in) begin
                buf_wr_data_out <= dd_in;
                buf_wr_out <= 1'b1;
            end else if (~odd_phase) begin
                odd_byte <= dd_in[7:0];
                odd_phase <= 1'b1;
            end else begin
                buf_wr_data_out <= {dd_in[7:0], odd_byte};
                buf_wr_out <= 1'b1;
                odd_phase <= 1'b0;
            end
        end
        if (wr_fall & cmd_blk) begin
            case (da_in)
                `ATATF_OFS_ERRFEAT: begin
                    feature_param_out <= dd_in[7:0];
                end
                `ATATF_OFS_SECCNT: begin
                    sector_count_out <= dd_in[7:0];
                end
                `ATATF_OFS_SECNUM: begin
                    sector_number <= dd_in[7:0];
                end
                `ATATF_OFS_CYLLO: begin
                    cylinder_low_byte <= dd_in[7:0];
                end
                `ATATF_OFS_CYLHI: begin
                    cylinder_high_byte <= dd_in[7:0];
                end
                `ATATF_OFS_DRVHEAD: begin
                    drive_head_select <= dd_in[7:0];
                end
                `ATATF_OFS_STATCMD: begin
                    if (selected) begin
                        command_code_out <= dd_in[7:0];
                        cmd_start_out <= 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end
        if (wr_fall & ctl_blk & (da_in == `ATATF_OFS_ALTCTL)) begin
            device_control_out <= dd_in[7:0];
        end
        addressing_mode_bit_out <= drive_head_select[`ATATF_DH_MODE_BIT];
        head_select_field_out <= drive_head_select[3:0];
        start_addr_out <= {drive_head_select[3:0], cylinder_high_byte,
                           cylinder_low_byte, sector_number};
        if (core_done_in) begin
            sector_count_out <= core_seccnt_in;
            sector_number <= core_addr_in[7:0];
            cylinder_low_byte <= core_addr_in[15:8];
            cylinder_high_byte <= core_addr_in[23:16];
            drive_head_select[3:0] <= core_addr_in[27:24];
        end
    end
end

// ****************************************
// Status and error flags.
// ****************************************
always @(posedge mclk_in) begin
    if (reset_in) begin
        error_flags <= `ATATF_BYTE_ZERO;
        status_primary <= `ATATF_STATUS_RESET;
    end else if (clk_en_in) begin
        status_primary <= core_status_in;
        if (|error_flags) begin
            status_primary[`ATATF_ST_ERR_BIT] <= 1'b1;
        end
        if (cmd_wr) begin
            error_flags <= `ATATF_BYTE_ZERO;
        end
        if (err_bad_block_in) begin
            error_flags[`ATATF_ERR_BBK_BIT] <= 1'b1;
        end
        if (err_uncorr_in) begin
            error_flags[`ATATF_ERR_UNC_BIT] <= 1'b1;
        end
        if (err_not_found_in) begin
            error_flags[`ATATF_ERR_SECTOR_NOT_FOUND_FLAG_BIT] <= 1'b1;
        end
        if (err_aborted_in) begin
            error_flags[`ATATF_ERR_ABORTED_FLAG_BIT] <= 1'b1;
        end
        if (err_general_in) begin
            error_flags[`ATATF_ERR_GEN_BIT] <= 1'b1;
        end
    end
end

endmodule // atatf_task_file

// [bench/atatf_task_file_asserts.sv]
// Port assertions of the task-file register bank.
`timescale 1ns/1ps
module atatf_task_file_asserts #(
    parameter DATA_W = 16
) (
    input wire              mclk_in,
    input wire              reset_in,
    input wire              cs0_n_in,
    input wire              cs1_n_in,
    input wire [2:0]        da_in,
    input wire              diow_n_in,
    input wire [DATA_W-1:0] dd_in,
    input wire              byte_mode_in,
    input wire              iocs16_n_out,
    input wire              cmd_start_out,
    input wire [7:0]        command_code_out,
    input wire [7:0]        feature_param_out,
    input wire [7:0]        device_control_out,
    input wire              addressing_mode_bit_out,
    input wire [3:0]        head_select_field_out
);
    // ****************************************
    // Decode helpers
    // ****************************************
    reg        wr_q;
    wire       cmd = !cs0_n_in && cs1_n_in;
    wire       ctl = cs0_n_in && !cs1_n_in;
    wire       we  = wr_q && !diow_n_in;
    wire       cw  = we && cmd && da_in == 3'h7;
    wire       fw  = we && cmd && da_in == 3'h1;
    wire       hw  = we && cmd && da_in == 3'h6;
    wire       dw  = we && ctl && da_in == 3'h6;
    wire       iw  = we && ctl && da_in == 3'h7;
    wire       bw  = we && !cs0_n_in && !cs1_n_in;
    wire       dp  = cmd && da_in == 3'h0;
    wire [7:0] lo  = dd_in[7:0];
    wire [4:0] dh  = {dd_in[6], dd_in[3:0]};
    always @(posedge mclk_in) begin
        wr_q <= diow_n_in;
    end
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (reset_in);
    cmd_source_a:
        assert property (cmd_start_out |-> $past(cw))
        else $error("command pulse without command write");
    cmd_code_a:
        assert property (cmd_start_out |-> command_code_out == $past(lo))
        else $error("command code mismatch");
    feature_load_a:
        assert property (fw |=> feature_param_out == $past(lo))
        else $error("feature byte not loaded");
    devctl_load_a:
        assert property (dw |=> device_control_out == $past(lo))
        else $error("device control not loaded");
    ctl_seven_a:
        assert property (iw |=> !cmd_start_out && $stable(device_control_out))
        else $error("control write at 7h not ignored");
    two_cs_a:
        assert property (bw |=> !cmd_start_out && $stable(device_control_out))
        else $error("write decoded with both selects");
    head_load_a:
        assert property (hw |-> ##2 {addressing_mode_bit_out,
            head_select_field_out} == $past(dh, 2))
        else $error("drive head fields not loaded");
    wide_port_a:
        assert property ((dp && !byte_mode_in) [*2] |-> !iocs16_n_out)
        else $error("16-bit indication missing");
    cover property (cmd_start_out);
    cover property (dp [*2]);
    cover property (bw);
endmodule // atatf_task_file_asserts

// [bench/atatf_host_model.sv]
// Host adapter model driving the task-file strobes.
`timescale 1ns/1ps
module atatf_host_model (
    input  wire        clk_in,
    input  wire [15:0] rd_in,
    input  wire        oe_in,
    output reg  [1:0]  cs_n_out,
    output reg  [2:0]  da_out,
    output reg         rd_n_out,
    output reg         wr_n_out,
    output reg  [15:0] wd_out
);
    // ****************************************
    // Strobed access
    // ****************************************
    reg oe_seen = 1'b0;
    initial begin
        cs_n_out = 2'h3;
        da_out = 3'h0;
        rd_n_out = 1'b1;
        wr_n_out = 1'b1;
        wd_out = 16'h0;
    end
    task access(input [1:0] c, input w, input [2:0] a, input [15:0] d,
                output [15:0] q);
        begin
            @(posedge clk_in);
            #1 cs_n_out = c;
            da_out = a;
            wd_out = d;
            oe_seen = 1'b0;
            @(posedge clk_in);
            #1 rd_n_out = w;
            wr_n_out = !w;
            repeat (3) begin
                @(posedge clk_in);
                oe_seen = oe_seen | oe_in;
            end
            q = oe_in ? rd_in : ~rd_in;
            #1 rd_n_out = 1'b1;
            wr_n_out = 1'b1;
            cs_n_out = 2'h3;
            da_out = ~a;
            wd_out = ~d;
        end
    endtask
endmodule // atatf_host_model

// [bench/ata_task_file_registers_tb.sv]
// Self-checking bench of the task-file register bank.
`timescale 1ns/1ps
`define CHK(n, e, v) begin comparisons++; if ((v) !== (e)) begin \
    error_cnt++; $display("CHECK FAILED %s exp %h got %h", n, e, v); end end
module ata_task_file_registers_tb;
    localparam [1:0] CB = 2'h2;
    localparam [1:0] CT = 2'h1;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        csel = 1'b0;
    logic        done = 1'b0;
    logic        bm = 1'b0;
    logic        wrt = 1'b0;
    logic [4:0]  err = 5'h0;
    logic [7:0]  stat = 8'h50;
    logic [15:0] bufd = 16'hbeef;
    logic [35:0] core = {8'h03, 28'h6abcdef};
    logic [15:0] q;
    logic [15:0] wdat = 16'h0;
    int          ncmd = 0;
    int          error_cnt = 0;
    int          comparisons = 0;
    wire  [1:0]  cs_n;
    wire  [2:0]  da;
    wire         rd_n, wr_n, oe, bwr, cst, mode, role;
    wire  [15:0] wd, dout, bwd;
    wire  [3:0]  head;
    wire  [7:0]  code, feat, dctl;
    wire  [27:0] sa;
    atatf_host_model h (.clk_in(clk), .rd_in(dout), .oe_in(oe),
        .cs_n_out(cs_n), .da_out(da), .rd_n_out(rd_n), .wr_n_out(wr_n),
        .wd_out(wd));
    atatf_task_file uut (.mclk_in(clk), .reset_in(rst), .clk_en_in(1'b1),
        .cs0_n_in(cs_n[0]), .cs1_n_in(cs_n[1]), .da_in(da), .dior_n_in(rd_n),
        .diow_n_in(wr_n), .dd_in(wd), .csel_in(csel), .byte_mode_in(bm),
        .buf_rd_data_in(bufd), .core_status_in(stat), .core_done_in(done),
        .core_seccnt_in(core[35:28]), .core_addr_in(core[27:0]),
        .core_writing_in(wrt), .err_bad_block_in(err[4]),
        .err_uncorr_in(err[3]), .err_not_found_in(err[2]),
        .err_aborted_in(err[1]), .err_general_in(err[0]), .dd_out(dout),
        .dd_oe_out(oe), .iocs16_n_out(), .iocs16_oe_out(), .buf_rd_out(),
        .buf_wr_out(bwr), .buf_wr_data_out(bwd), .cmd_start_out(cst),
        .command_code_out(code), .feature_param_out(feat),
        .device_control_out(dctl), .addressing_mode_bit_out(mode),
        .head_select_field_out(head), .start_addr_out(sa),
        .sector_count_out(), .drive_role_out(role));
    always @(posedge clk) begin
        if (cst) ncmd <= ncmd + 1;
        if (bwr) wdat <= bwd;
    end
    // ****************************************
    // Scenarios
    // ****************************************
    task wr(input [1:0] c, input [2:0] a, input [15:0] d);
        h.access(c, 1'b1, a, d, q);
    endtask
    task rd(input [1:0] c, input [2:0] a, input [15:0] e);
        begin
            h.access(c, 1'b0, a, 16'h0, q);
            `CHK("read data", e, q)
        end
    endtask
    task t_regs;
        int i;
        begin
            for (i = 2; i < 7; i++) wr(CB, i[2:0], 16'h11 * i[15:0]);
            for (i = 2; i < 7; i++) rd(CB, i[2:0], 16'h11 * i[15:0]);
            `CHK("start address", 28'h6554433, sa)
            `CHK("mode and head", 5'h16, {mode, head})
            @(posedge clk);
            #1 done = 1'b1;
            @(posedge clk);
            #1 done = 1'b0;
            rd(CB, 3'h2, 16'h0003);
            rd(CB, 3'h3, 16'h00ef);
            rd(CB, 3'h4, 16'h00cd);
            rd(CB, 3'h5, 16'h00ab);
        end
    endtask
    task t_err;
        begin
            wr(CB, 3'h1, 16'h00ff);
            `CHK("feature", 8'hff, feat)
            @(posedge clk);
            #1 err = 5'h1f;
            @(posedge clk);
            #1 err = 5'h0;
            rd(CB, 3'h1, 16'h00d5);
            rd(CB, 3'h7, 16'h0051);
            rd(CT, 3'h6, 16'h0051);
            wr(CB, 3'h7, 16'h00ec);
            `CHK("command", 8'hec, code)
            rd(CB, 3'h1, 16'h0000);
        end
    endtask
    task t_ctl;
        begin
            wr(CT, 3'h6, 16'h000a);
            wr(CT, 3'h7, 16'h00ff);
            `CHK("device control", 8'h0a, dctl)
            rd(CT, 3'h7, 16'h00e6);
            wr(2'h0, 3'h7, 16'h0020);
            wr(2'h3, 3'h7, 16'h0020);
            `CHK("command count", 1, ncmd)
            rd(CB, 3'h0, 16'hbeef);
            wr(CB, 3'h0, 16'hcafe);
            `CHK("buffer word", 16'hcafe, wdat)
            bm = 1'b1;
            rd(CB, 3'h0, 16'h00ef);
            rd(CB, 3'h0, 16'h00be);
            wr(CB, 3'h0, 16'h0034);
            wr(CB, 3'h0, 16'h0012);
            `CHK("byte pair", 16'h1234, wdat)
            bm = 1'b0;
            wrt = 1'b1;
            rd(CT, 3'h7, 16'h00a6);
            wrt = 1'b0;
            csel = 1'b1;
            h.access(CB, 1'b0, 3'h7, 16'h0, q);
            `CHK("drive role", 1'b1, role)
            `CHK("read answered", 1'b0, h.oe_seen)
        end
    endtask
    task tally_and_finish;
        begin
            $display("mismatches %0d comparisons %0d", error_cnt, comparisons);
            if (error_cnt == 0 && comparisons > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask
    initial begin
        forever #50 clk = ~clk;
    end
    initial begin
        repeat (6) @(posedge clk);
        #1 rst = 1'b0;
        t_regs;
        t_err;
        t_ctl;
        tally_and_finish;
    end
endmodule // ata_task_file_registers_tb
bind atatf_task_file atatf_task_file_asserts #(.DATA_W(DATA_W)) chk (
    .mclk_in(mclk_in), .reset_in(reset_in), .cs0_n_in(cs0_n_in),
    .cs1_n_in(cs1_n_in), .da_in(da_in), .diow_n_in(diow_n_in),
    .dd_in(dd_in), .byte_mode_in(byte_mode_in), .iocs16_n_out(iocs16_n_out),
    .cmd_start_out(cmd_start_out), .command_code_out(command_code_out),
    .feature_param_out(feature_param_out),
    .device_control_out(device_control_out),
    .addressing_mode_bit_out(addressing_mode_bit_out),
    .head_select_field_out(head_select_field_out));
